// >>> flk_flash_key_lock.v
/*
 Flash key guard. Decodes key-register writes, tracks the lock state,
 steers core data-memory writes either to data memory or to the flash
 controller, and reports the lock state on register reads.
 Assumes the core issues one-cycle sfr and data-memory strobes on clk_sys
 and that the flash controller answers each request with a one-cycle
 flashDone pulse, some cycles later.
*/
`timescale 1ns/10ps
`include "flk_map.vh"

module flk_flash_key_lock #(
   parameter ADDR_W = 16
) (
   input wire clk_sys,
   input wire reset,
   input wire [7:0] sfrAddr,
   input wire sfrWrite,
   input wire [7:0] sfrWdata,
   input wire sfrRead,
   output reg [7:0] sfrRdata,
   output reg sfrReadHit,
   input wire memWrite,
   input wire [ADDR_W-1:0] memAddr,
   input wire [7:0] memWdata,
   output reg xramWrite,
   output reg [ADDR_W-1:0] xramAddr,
   output reg [7:0] xramWdata,
   output reg flashWriteReq,
   output reg flashEraseReq,
   output reg [ADDR_W-1:0] flashAddr,
   output reg [7:0] flashWdata,
   input wire flashDone,
   output reg flashBlocked,
   output wire [1:0] lockState
);

   // ===============================================================
   // States
   localparam [4:0] ST_LOCKED = 5'h01;
   localparam [4:0] ST_FIRST = 5'h02;
   localparam [4:0] ST_OPEN = 5'h04;
   localparam [4:0] ST_BUSY = 5'h08;
   localparam [4:0] ST_PERM = 5'h10;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [1:0] code;
   wire programWriteEnable;
   wire programEraseEnable;
   wire keyWrite;
   wire flashAccess;
   wire opAccepted;

   // ===============================================================
   // State to reported lock code
   function [1:0] stateCode;
      input [4:0] st;
      begin
         case (st)
            ST_LOCKED: stateCode = `FLK_CODE_LOCKED;
            ST_FIRST: stateCode = `FLK_CODE_FIRST;
            ST_OPEN: stateCode = `FLK_CODE_OPEN;
            // Still open until the single operation finishes
            ST_BUSY: stateCode = `FLK_CODE_OPEN;
            ST_PERM: stateCode = `FLK_CODE_PERM;
            default: stateCode = `FLK_CODE_PERM;
         endcase
      end
   endfunction

   // ===============================================================
   // Program store control register
   flk_psctl_reg u_psctl (
      .clk_sys(clk_sys),
      .reset(reset),
      .sfrWrite(sfrWrite),
      .sfrAddr(sfrAddr),
      .sfrWdata(sfrWdata),
      .programWriteEnable(programWriteEnable),
      .programEraseEnable(programEraseEnable)
   );

   assign keyWrite = sfrWrite && (sfrAddr == `FLK_ADDR_KEY);
   // Writes reach flash only with write enable set
   assign flashAccess = memWrite && programWriteEnable;
   // Only the one operation started from the open state goes out
   assign opAccepted = flashAccess && (state_r == ST_OPEN);

   // ===============================================================
   // Lock state machine
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_LOCKED: begin
            if (flashAccess) begin
               state_nxt = ST_PERM;
            end else if (keyWrite) begin
               if (sfrWdata == `FLK_KEY_FIRST) begin
                  state_nxt = ST_FIRST;
               end else begin
                  // Any other first byte, 0xf1 included, locks for good
                  state_nxt = ST_PERM;
               end
            end
         end
         ST_FIRST: begin
            if (flashAccess) begin
               state_nxt = ST_PERM;
            end else if (keyWrite) begin
               if (sfrWdata == `FLK_KEY_SECOND) begin
                  state_nxt = ST_OPEN;
               end else begin
                  state_nxt = ST_PERM;
               end
            end
         end
         ST_OPEN: begin
            // A stray flashDone with nothing running is ignored here
            if (flashAccess) begin
               state_nxt = ST_BUSY;
            end else if (keyWrite) begin
               // Another key write while open breaks the sequence
               state_nxt = ST_PERM;
            end
         end
         ST_BUSY: begin
            if (flashAccess || keyWrite) begin
               // A second access during the operation is not covered by
               // the key; the running operation still completes
               state_nxt = ST_PERM;
            end else if (flashDone) begin
               state_nxt = ST_LOCKED;
            end
         end
         ST_PERM: begin
            state_nxt = ST_PERM;
         end
         default: begin
            state_nxt = ST_PERM;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         // Reset is the only way out of the permanent lock
         state_r <= ST_LOCKED;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign lockState = stateCode(state_r);

   // ===============================================================
   // Data-memory and flash steering
   // Outputs are registered, so each request appears one cycle after
   // the core strobe; the flash controller sees a clean pulse
   always @(posedge clk_sys) begin
      if (reset) begin
         xramWrite <= 1'b0;
         xramAddr <= {ADDR_W{1'b0}};
         xramWdata <= 8'h00;
         flashWriteReq <= 1'b0;
         flashEraseReq <= 1'b0;
         flashAddr <= {ADDR_W{1'b0}};
         flashWdata <= 8'h00;
         flashBlocked <= 1'b0;
      end else begin
         xramWrite <= memWrite && !programWriteEnable;
         if (memWrite && !programWriteEnable) begin
            xramAddr <= memAddr;
            xramWdata <= memWdata;
         end
         // Erase and byte write share one gate
         flashWriteReq <= opAccepted && !programEraseEnable;
         flashEraseReq <= opAccepted && programEraseEnable;
         if (opAccepted) begin
            flashAddr <= memAddr;
            // Data is carried but ignored by the controller on erase
            flashWdata <= memWdata;
         end
         // A refused access reaches neither data memory nor flash
         flashBlocked <= flashAccess && !opAccepted;
      end
   end

   // ===============================================================
   // Register read port
   // Reads never move the key sequence; only key writes, flash accesses and flashDone do
   always @* begin
      code = stateCode(state_r);
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         sfrRdata <= 8'h00;
         sfrReadHit <= 1'b0;
      end else begin
         sfrReadHit <= 1'b0;
         sfrRdata <= 8'h00;
         if (sfrRead) begin
            case (sfrAddr)
               `FLK_ADDR_KEY: begin
                  sfrRdata <= {6'h00, code};
                  sfrReadHit <= 1'b1;
               end
               `FLK_ADDR_PSCTL: begin
                  sfrRdata <= {6'h00, programEraseEnable,
                               programWriteEnable};
                  sfrReadHit <= 1'b1;
               end
               default: begin
                  sfrRdata <= 8'h00;
                  sfrReadHit <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // flk_flash_key_lock

// >>> flk_flash_key_lock_bench.sv
/* Directed bench for the flash key guard: key sequences, steering, reads.
 Assumes the design and its checker are compiled ahead of it. */
`timescale 1ns/10ps
`include "flk_map.vh"
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin err_count++; \
 $display("ERROR %s exp %h got %h", n, e, g); end end
// ====
// Bench
module flk_flash_key_lock_bench;
   reg clk_sys = 0, reset = 1, sfrWrite = 0, sfrRead = 0, memWrite = 0;
   reg flashDone = 0;
   reg [7:0] sfrAddr = 0, sfrWdata = 0, memWdata = 0;
   reg [15:0] memAddr = 0;
   wire [7:0] sfrRdata, xramWdata, flashWdata;
   wire [15:0] xramAddr, flashAddr;
   wire sfrReadHit, xramWrite, flashWriteReq, flashEraseReq, flashBlocked;
   wire [1:0] lockState;
   integer err_count = 0, checks = 0, cyc = 0, i;
   flk_flash_key_lock DUT (.clk_sys, .reset, .sfrAddr, .sfrWrite, .sfrWdata,
      .sfrRead, .sfrRdata, .sfrReadHit, .memWrite, .memAddr, .memWdata,
      .xramWrite, .xramAddr, .xramWdata, .flashWriteReq, .flashEraseReq,
      .flashAddr, .flashWdata, .flashDone, .flashBlocked, .lockState);
   initial forever #5 clk_sys = ~clk_sys;
   task final_report;
      begin
         $display("checks %0d errors %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // A hang would otherwise run forever; the tests need about 110 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         err_count++;
         final_report;
      end
   end
   // One-cycle strobe s = {flashDone, memWrite, sfrRead, sfrWrite}
   task op(input [3:0] s, input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         {flashDone, memWrite, sfrRead, sfrWrite} <= s;
         sfrAddr <= a;
         sfrWdata <= d;
         memAddr <= {a, d};
         memWdata <= d;
         @(posedge clk_sys);
         {flashDone, memWrite, sfrRead, sfrWrite} <= 4'h0;
         #1;
      end
   endtask
   task key(input [7:0] d, input [1:0] e);
      begin
         op(4'h1, `FLK_ADDR_KEY, d);
         `CHK("lockState", e, lockState)
      end
   endtask
   task rst;
      begin
         @(posedge clk_sys);
         reset <= 1'b1;
         repeat (2) @(posedge clk_sys);
         reset <= 1'b0;
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      op(4'h2, `FLK_ADDR_KEY, 8'h00);
      `CHK("rdKey", 9'h100, {sfrReadHit, sfrRdata})
      op(4'h2, 8'h12, 8'h00);
      `CHK("rdUnmapped", 9'h000, {sfrReadHit, sfrRdata})
      op(4'h4, 8'h20, 8'h5a);
      `CHK("xram", 26'h240b4b4, {xramWrite, xramAddr, xramWdata,
         flashWriteReq})
      key(`FLK_KEY_FIRST, `FLK_CODE_FIRST);
      op(4'h1, `FLK_ADDR_PSCTL, 8'h01);
      op(4'h2, `FLK_ADDR_PSCTL, 8'h00);
      `CHK("rdPsctl", 8'h01, sfrRdata)
      key(`FLK_KEY_SECOND, `FLK_CODE_OPEN);
      op(4'h2, `FLK_ADDR_KEY, 8'h00);
      `CHK("rdOpen", `FLK_CODE_OPEN, sfrRdata[1:0])
      op(4'h4, 8'h31, 8'h77);
      `CHK("wr", 27'h4317777, {flashWriteReq, flashEraseReq, flashBlocked,
         flashAddr, flashWdata})
      op(4'h8, 8'h00, 8'h00);
      `CHK("close", `FLK_CODE_LOCKED, lockState)
      key(`FLK_KEY_FIRST, `FLK_CODE_FIRST);
      key(`FLK_KEY_SECOND, `FLK_CODE_OPEN);
      op(4'h1, `FLK_ADDR_PSCTL, 8'h03);
      op(4'h4, 8'h40, 8'h99);
      `CHK("erase", 19'h24099, {flashWriteReq, flashEraseReq, flashBlocked,
         flashAddr})
      op(4'h8, 8'h00, 8'h00);
      `CHK("close2", `FLK_CODE_LOCKED, lockState)
      op(4'h4, 8'h41, 8'h00);
      `CHK("blocked", 3'h1, {flashWriteReq, flashEraseReq, flashBlocked})
      `CHK("perm", `FLK_CODE_PERM, lockState)
      key(`FLK_KEY_FIRST, `FLK_CODE_PERM);
      key(`FLK_KEY_SECOND, `FLK_CODE_PERM);
      op(4'h2, `FLK_ADDR_KEY, 8'h00);
      `CHK("rdPerm", `FLK_CODE_PERM, sfrRdata[1:0])
      rst;
      op(4'h2, `FLK_ADDR_PSCTL, 8'h00);
      `CHK("psctlReset", 8'h00, sfrRdata)
      key(8'h00, `FLK_CODE_PERM);
      for (i = 0; i < 2; i++) begin
         rst;
         key(i ? 8'h3c : `FLK_KEY_SECOND, `FLK_CODE_PERM);
      end
      rst;
      key(`FLK_KEY_FIRST, `FLK_CODE_FIRST);
      key(`FLK_KEY_FIRST, `FLK_CODE_PERM);
      rst;
      key(`FLK_KEY_FIRST, `FLK_CODE_FIRST);
      key(`FLK_KEY_SECOND, `FLK_CODE_OPEN);
      key(`FLK_KEY_FIRST, `FLK_CODE_PERM);
      rst;
      op(4'h1, `FLK_ADDR_PSCTL, 8'h02);
      op(4'h4, 8'h50, 8'h11);
      `CHK("eraseOnly", 4'h8, {xramWrite, flashWriteReq, flashEraseReq,
         flashBlocked})
      `CHK("eraseOnlyLock", `FLK_CODE_LOCKED, lockState)
      op(4'h1, `FLK_ADDR_PSCTL, 8'h01);
      key(`FLK_KEY_FIRST, `FLK_CODE_FIRST);
      key(`FLK_KEY_SECOND, `FLK_CODE_OPEN);
      op(4'h4, 8'h60, 8'h22);
      `CHK("wrBusy", 3'h4, {flashWriteReq, flashEraseReq,
         flashBlocked})
      op(4'h4, 8'h61, 8'h23);
      `CHK("second", 19'h16022, {flashWriteReq, flashEraseReq, flashBlocked,
         flashAddr})
      `CHK("secondPerm", `FLK_CODE_PERM, lockState)
      op(4'h8, 8'h00, 8'h00);
      `CHK("donePerm", `FLK_CODE_PERM, lockState)
      final_report;
   end
endmodule // flk_flash_key_lock_bench

// >>> flk_lock_props.sv
/* Port-level assertions for the flash key guard.
 Assumes one clock, clk_sys, and a synchronous active-high reset. */
`timescale 1ns/10ps
`include "flk_map.vh"
// ====
// Checker
module flk_lock_props (
   input wire clk_sys,
   input wire reset,
   input wire [7:0] sfrAddr,
   input wire sfrWrite,
   input wire [7:0] sfrWdata,
   input wire sfrRead,
   input wire [7:0] sfrRdata,
   input wire sfrReadHit,
   input wire memWrite,
   input wire xramWrite,
   input wire flashWriteReq,
   input wire flashEraseReq,
   input wire flashDone,
   input wire flashBlocked,
   input wire [1:0] lockState
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // A flash access wins over a key write in the same cycle, so leave out any memory write
   wire keyW = sfrWrite && sfrAddr == `FLK_ADDR_KEY && !memWrite;
   wire goodA = sfrWdata == `FLK_KEY_FIRST && lockState == `FLK_CODE_LOCKED;
   wire goodB = sfrWdata == `FLK_KEY_SECOND && lockState == `FLK_CODE_FIRST;
   wire anyOut = xramWrite | flashWriteReq | flashEraseReq | flashBlocked;
   key_first_a: assert property (keyW && goodA |=> lockState == 2'h1)
      else $error("first key not accepted");
   key_open_a: assert property (keyW && goodB |=> lockState == 2'h2)
      else $error("second key did not open");
   bad_key_a: assert property (keyW && !goodA && !goodB |=> lockState == 2'h3)
      else $error("wrong key did not lock");
   op_close_a: assert property (flashDone && lockState == 2'h2 && !sfrWrite
      && !memWrite |=> lockState == 2'h0)
      else $error("guard not closed after op");
   blocked_lock_a: assert property (flashBlocked |-> lockState == 2'h3)
      else $error("refusal without permanent lock");
   perm_hold_a: assert property (lockState == 2'h3 |=> lockState == 2'h3)
      else $error("permanent lock left");
   req_open_a: assert property (flashWriteReq || flashEraseReq |->
      $past(memWrite) && $past(lockState) == 2'h2)
      else $error("flash request while not open");
   one_kind_a: assert property (anyOut |-> $onehot({xramWrite, flashWriteReq,
      flashEraseReq, flashBlocked}) && $past(memWrite))
      else $error("steering outputs collide");
   read_code_a: assert property (sfrRead && sfrAddr == `FLK_ADDR_KEY |=>
      sfrReadHit && sfrRdata[1:0] == $past(lockState))
      else $error("key read gave wrong code");
   cover property (flashWriteReq);
   cover property (flashEraseReq);
   cover property (flashBlocked);
endmodule // flk_lock_props
bind flk_flash_key_lock flk_lock_props u_props (
   .clk_sys(clk_sys),
   .reset(reset),
   .sfrAddr(sfrAddr),
   .sfrWrite(sfrWrite),
   .sfrWdata(sfrWdata),
   .sfrRead(sfrRead),
   .sfrRdata(sfrRdata),
   .sfrReadHit(sfrReadHit),
   .memWrite(memWrite),
   .xramWrite(xramWrite),
   .flashWriteReq(flashWriteReq),
   .flashEraseReq(flashEraseReq),
   .flashDone(flashDone),
   .flashBlocked(flashBlocked),
   .lockState(lockState)
);

// >>> flk_map.vh
/*
 Constants for the flash key guard: special-function register addresses,
 field positions, reset values, key bytes and the reported lock codes.
 Assumes inclusion by bare name from every design file that needs them.
*/
// Behaviour
// - Flash write and erase open only after key byte 0xA5 and then, as the very next key write, 0xF1.
// - Once open, exactly one flash write or erase is allowed and the guard closes when it completes.
// - A key write that breaks the sequence locks flash permanently.
// - A flash write or erase tried while not open is blocked and locks flash permanently.
// - The permanent lock survives all key writes and only device reset returns the plain locked state.
// - Reading the key register gives the state in bits 1-0: 00 locked, 01 first key, 10 open, 11 locked until reset.
// - Byte writes and page erasures pass through the same key sequence and lock state.
// - A data-memory write goes to flash only while program_write_enable is 1.
// - With program_write_enable and program_erase_enable both 1, a flash write erases the page whatever the data.
`ifndef FLK_MAP_VH
`define FLK_MAP_VH

// ===============================================================
// Register addresses
`define FLK_ADDR_KEY 8'hb7
`define FLK_ADDR_PSCTL 8'h8f

// ===============================================================
// Fields and reset values
`define FLK_PSCTL_WE_BIT 0
`define FLK_PSCTL_EE_BIT 1
`define FLK_PSCTL_RESET 2'h0
`define FLK_KEY_RESET 8'h00

// ===============================================================
// Key bytes
`define FLK_KEY_FIRST 8'ha5
`define FLK_KEY_SECOND 8'hf1

// ===============================================================
// Lock codes reported in bits 1-0
`define FLK_CODE_LOCKED 2'h0
`define FLK_CODE_FIRST 2'h1
`define FLK_CODE_OPEN 2'h2
`define FLK_CODE_PERM 2'h3

`endif

// >>> flk_psctl_reg.v
/*
 Program store control register: holds program_write_enable and
 program_erase_enable, written and read over the special-function bus.
 Assumes single-cycle write strobes synchronous to clk_sys.
*/
`timescale 1ns/10ps
`include "flk_map.vh"

module flk_psctl_reg (
   input wire clk_sys,
   input wire reset,
   input wire sfrWrite,
   input wire [7:0] sfrAddr,
   input wire [7:0] sfrWdata,
   output wire programWriteEnable,
   output wire programEraseEnable
);

   reg [1:0] ctl_r;
   wire [1:0] ctl_nxt;

   // ===============================================================
   // Register
   // Reserved bits 7:2 are not stored; they read back as zero
   assign ctl_nxt = (sfrWrite && sfrAddr == `FLK_ADDR_PSCTL) ?
                    sfrWdata[1:0] : ctl_r;

   always @(posedge clk_sys) begin
      if (reset) begin
         ctl_r <= `FLK_PSCTL_RESET;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   assign programWriteEnable = ctl_r[`FLK_PSCTL_WE_BIT];
   assign programEraseEnable = ctl_r[`FLK_PSCTL_EE_BIT];

endmodule // flk_psctl_reg
